// >>> logic/qpc_pkg.sv
// Constants, field layouts and carrier types for the quadrature position controller
package qpc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int POS_W = 32;
    localparam int CTRL_W = 16;
    localparam int DIV_CNT_W = 7;

    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_POS = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_INIT = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_GEC = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_INCFG = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_STAT = 8'h14;

    // Control register field positions
    localparam int CTRL_RUN_BIT = 15;
    localparam int CTRL_HALT_IDLE_BIT = 13;
    localparam int CTRL_INIT_MODE_LSB = 10;
    localparam int CTRL_IMV_LSB = 8;
    localparam int CTRL_DIV_LSB = 4;
    localparam int CTRL_POL_BIT = 3;
    localparam int CTRL_GATE_BIT = 2;
    localparam int CTRL_CCM_LSB = 0;
    localparam logic [CTRL_W-1:0] CTRL_WRITE_MASK = 16'hbf7f;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;

    // Input conditioning register bits
    localparam int INCFG_W = 4;
    localparam logic [INCFG_W-1:0] INCFG_RESET = 4'h0;
    localparam int INCFG_SWAP_BIT = 0;
    localparam int INCFG_INV_A_BIT = 1;
    localparam int INCFG_INV_B_BIT = 2;
    localparam int INCFG_INV_IDX_BIT = 3;

    localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
    localparam logic [POS_W-1:0] POS_ONE = 32'h0000_0001;

    localparam logic [2:0] INIT_NONE = 3'h0;
    localparam logic [2:0] INIT_IDX_RESET = 3'h1;
    localparam logic [2:0] INIT_NEXT_IDX = 3'h2;
    localparam logic [2:0] INIT_HOME_IDX1 = 3'h3;
    localparam logic [2:0] INIT_HOME_IDX2 = 3'h4;
    localparam logic [2:0] INIT_GE_RESET = 3'h5;
    localparam logic [2:0] INIT_MODULO = 3'h6;

    localparam logic [1:0] CCM_QUAD = 2'h0;
    localparam logic [1:0] CCM_EXT_CLK = 2'h1;

    typedef struct packed {
        logic runEnable;
        logic rsvd14;
        logic haltInIdle;
        logic [2:0] positionInitMode;
        logic [1:0] indexMatchState;
        logic rsvd7;
        logic [2:0] inputClockDivider;
        logic countDirectionPolarity;
        logic externalGateEnable;
        logic [1:0] counterModeSelect;
    } qpc_ctrl_s;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } qpc_apb_req_s;

    typedef struct packed {
        logic phaseA;
        logic phaseB;
        logic index;
        logic home;
    } qpc_enc_s;

    typedef enum logic [3:0] {
        ARM_OFF = 4'b0001,
        ARM_SEEK_HOME = 4'b0010,
        ARM_SKIP_IDX = 4'b0100,
        ARM_LOAD_IDX = 4'b1000
    } qpc_arm_e;
endpackage

// >>> logic/qpc_position_ctrl.sv
// Quadrature position counter with APB control registers
// What this block does
// - The counters advance only while the run-enable bit 15 is set; registers stay accessible.
// - With halt-in-idle bit 13 set the block stops while the device is idle.
// - Init mode 000 ignores index events outside counter mode 00, mode 001 resets the position on every index event.
// - Init mode 010 loads the init value register on the next index event.
// - Init mode 011 loads the init value on the first index event after a home event.
// - Init mode 100 loads the init value on the second index event after a home event.
// - Init mode 101 resets the position whenever it equals the compare register.
// - Init mode 110 makes the position count modulo; code 111 is reserved for software.
// - Index match bits 9-8 give the phase B and phase A states an index must meet in counter mode 00.
// - Counter modes 10 and 11 run all counters as timers and ignore the init mode.
// - In counter mode 00 a matched index resets the position whatever the init mode.
// - The index match uses phase A and B after swap and inversion.
// - Control bits 14 and 7 read zero and every control bit resets to zero.
`timescale 1ns/100ps
`default_nettype none
module qpc_position_ctrl (
    input wire logic clk,
    input wire logic rst_b,
    input wire qpc_pkg::qpc_apb_req_s apbReq,
    output logic [qpc_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire qpc_pkg::qpc_enc_s encIn,
    input wire logic deviceIdle,
    output logic countUp,
    output logic counterActive
);
    import qpc_pkg::*;

    qpc_ctrl_s ctrl;
    logic [INCFG_W-1:0] inCfg;
    logic [POS_W-1:0] position;
    logic [POS_W-1:0] initValue;
    logic [POS_W-1:0] geCompare;
    qpc_arm_e armState;
    logic [DIV_CNT_W-1:0] divCnt;
    logic sampA;
    logic sampB;
    logic sampIdx;
    logic prevA;
    logic prevB;
    logic prevIdx;
    logic prevHome;
    logic sampHome;

    // Bus decode
    logic setupPhase;
    logic accessDone;
    logic wrEn;
    logic addrHit;
    logic wrCtrl;
    logic wrPos;
    logic wrInit;
    logic wrGec;
    logic wrInCfg;
    logic [DATA_W-1:0] next_prdata;

    assign setupPhase = apbReq.psel & ~apbReq.penable;
    assign accessDone = apbReq.psel & apbReq.penable & pready;
    assign wrEn = accessDone & apbReq.pwrite & addrHit;
    assign wrCtrl = wrEn & (apbReq.paddr == OFF_CTRL);
    assign wrPos = wrEn & (apbReq.paddr == OFF_POS);
    assign wrInit = wrEn & (apbReq.paddr == OFF_INIT);
    assign wrGec = wrEn & (apbReq.paddr == OFF_GEC);
    assign wrInCfg = wrEn & (apbReq.paddr == OFF_INCFG);

    always_comb
    begin
        addrHit = 1'b1;
        next_prdata = '0;
        case (apbReq.paddr)
            OFF_CTRL: next_prdata = {16'h0000, ctrl};
            OFF_POS: next_prdata = position;
            OFF_INIT: next_prdata = initValue;
            OFF_GEC: next_prdata = geCompare;
            OFF_INCFG: next_prdata = {28'h0000000, inCfg};
            OFF_STAT: next_prdata = {28'h0000000, armState};
            default: addrHit = 1'b0;
        endcase
    end

    // No wait state: pready rises in the cycle after setup and the access ends there
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end
        else
        begin
            pready <= setupPhase;
            pslverr <= setupPhase & ~addrHit;
            if (setupPhase)
            begin
                prdata <= apbReq.pwrite ? '0 : next_prdata;
            end
        end
    end

    // Control register; reserved bits masked so they always read zero
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl <= CTRL_RESET;
        end
        else if (wrCtrl)
        begin
            ctrl <= apbReq.pwdata[CTRL_W-1:0] & CTRL_WRITE_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            inCfg <= INCFG_RESET;
            initValue <= POS_RESET;
            geCompare <= POS_RESET;
        end
        else
        begin
            if (wrInCfg)
            begin
                inCfg <= apbReq.pwdata[INCFG_W-1:0];
            end
            if (wrInit)
            begin
                initValue <= apbReq.pwdata;
            end
            if (wrGec)
            begin
                geCompare <= apbReq.pwdata;
            end
        end
    end

    // Run qualification
    logic running;
    logic timerMode;
    assign running = ctrl.runEnable & ~(ctrl.haltInIdle & deviceIdle);
    assign timerMode = ctrl.counterModeSelect[1];

    // Input divider: inputs are sampled only on divider ticks, which filters glitches
    logic divTick;
    logic [DIV_CNT_W-1:0] divLast;
    assign divLast = DIV_CNT_W'((8'h01 << ctrl.inputClockDivider) - 8'h01);
    assign divTick = running & (divCnt >= divLast);

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            divCnt <= '0;
        end
        else if (!running || divTick)
        begin
            divCnt <= '0;
        end
        else
        begin
            divCnt <= divCnt + 1'b1;
        end
    end

    // Swap and inversion are applied before any decoding or index matching
    logic condA;
    logic condB;
    logic condIdx;
    assign condA = (inCfg[INCFG_SWAP_BIT] ? encIn.phaseB : encIn.phaseA) ^ inCfg[INCFG_INV_A_BIT];
    assign condB = (inCfg[INCFG_SWAP_BIT] ? encIn.phaseA : encIn.phaseB) ^ inCfg[INCFG_INV_B_BIT];
    assign condIdx = encIn.index ^ inCfg[INCFG_INV_IDX_BIT];

    // Samplers stall with the counter, so a change made during the stall is seen as an edge after re-enable
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sampA <= 1'b0;
            sampB <= 1'b0;
            sampIdx <= 1'b0;
            sampHome <= 1'b0;
            prevA <= 1'b0;
            prevB <= 1'b0;
            prevIdx <= 1'b0;
            prevHome <= 1'b0;
        end
        else if (divTick)
        begin
            prevA <= sampA;
            prevB <= sampB;
            prevIdx <= sampIdx;
            prevHome <= sampHome;
            sampA <= condA;
            sampB <= condB;
            sampIdx <= condIdx;
            sampHome <= encIn.home;
        end
    end

    // Edge and step detection on conditioned samples
    logic idxRise;
    logic homeRise;
    logic idxMatch;
    logic idxEvent;
    logic stepValid;
    logic stepUp;
    assign idxRise = divTick & sampIdx & ~prevIdx;
    assign homeRise = divTick & sampHome & ~prevHome;
    assign idxMatch = (sampB == ctrl.indexMatchState[1]) & (sampA == ctrl.indexMatchState[0]);
    assign idxEvent = idxRise & ~timerMode &
        ((ctrl.counterModeSelect == CCM_QUAD) ? idxMatch : 1'b1);

    always_comb
    begin
        stepValid = 1'b0;
        stepUp = 1'b1;
        case (ctrl.counterModeSelect)
            CCM_QUAD:
            begin
                stepValid = divTick & ((sampA ^ prevA) ^ (sampB ^ prevB));
                stepUp = (prevA ^ sampB) ^ ctrl.countDirectionPolarity;
            end
            CCM_EXT_CLK:
            begin
                stepValid = divTick & sampA & ~prevA;
                stepUp = ~sampB ^ ctrl.countDirectionPolarity;
            end
            default:
            begin
                // Timer: gate input holds the count while low when gating is on
                stepValid = divTick & (~ctrl.externalGateEnable | sampIdx);
                stepUp = ~ctrl.countDirectionPolarity;
            end
        endcase
    end

    // Home and index arming for the one-shot initialisation modes
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            armState <= ARM_OFF;
        end
        else if (wrCtrl)
        begin
            case (apbReq.pwdata[CTRL_INIT_MODE_LSB +: 3])
                INIT_NEXT_IDX: armState <= ARM_LOAD_IDX;
                INIT_HOME_IDX1: armState <= ARM_SEEK_HOME;
                INIT_HOME_IDX2: armState <= ARM_SEEK_HOME;
                default: armState <= ARM_OFF;
            endcase
        end
        else if (running && !timerMode)
        begin
            case (armState)
                ARM_OFF:
                begin
                    // A later home re-arms the home-qualified modes
                    if (homeRise && (ctrl.positionInitMode == INIT_HOME_IDX1 ||
                        ctrl.positionInitMode == INIT_HOME_IDX2))
                    begin
                        armState <= ARM_SEEK_HOME;
                    end
                end
                ARM_SEEK_HOME:
                begin
                    if (homeRise)
                    begin
                        armState <= (ctrl.positionInitMode == INIT_HOME_IDX2) ?
                            ARM_SKIP_IDX : ARM_LOAD_IDX;
                    end
                end
                ARM_SKIP_IDX:
                begin
                    if (idxEvent)
                    begin
                        armState <= ARM_LOAD_IDX;
                    end
                end
                ARM_LOAD_IDX:
                begin
                    if (idxEvent)
                    begin
                        armState <= ARM_OFF;
                    end
                end
                default: armState <= ARM_OFF;
            endcase
        end
    end

    // Position counter
    logic [POS_W-1:0] stepped;
    assign stepped = stepUp ? position + POS_ONE : position - POS_ONE;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            position <= POS_RESET;
        end
        else if (wrPos)
        begin
            position <= apbReq.pwdata;
        end
        else if (!running)
        begin
            position <= position;
        end
        else if (timerMode)
        begin
            if (stepValid)
            begin
                position <= stepped;
            end
        end
        else if (idxEvent && (ctrl.counterModeSelect == CCM_QUAD ||
            ctrl.positionInitMode == INIT_IDX_RESET))
        begin
            position <= POS_RESET;
        end
        else if (idxEvent && armState == ARM_LOAD_IDX)
        begin
            position <= initValue;
        end
        else if (ctrl.positionInitMode == INIT_GE_RESET && position == geCompare)
        begin
            position <= POS_RESET;
        end
        else if (stepValid)
        begin
            if (ctrl.positionInitMode == INIT_MODULO && stepUp && position == geCompare)
            begin
                position <= initValue;
            end
            else if (ctrl.positionInitMode == INIT_MODULO && !stepUp && position == initValue)
            begin
                position <= geCompare;
            end
            else
            begin
                position <= stepped;
            end
        end
    end

    // Status outputs
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            countUp <= 1'b1;
            counterActive <= 1'b0;
        end
        else
        begin
            counterActive <= running;
            if (stepValid)
            begin
                countUp <= stepUp;
            end
        end
    end
endmodule
`default_nettype wire

// >>> dv/qpc_enc_model.sv
// Behavioural quadrature encoder: phase pair, index and home levels
`timescale 1ns/100ps
`default_nettype none
module qpc_enc_model (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic stepGo,
    input wire logic stepFwd,
    input wire logic idxLvl,
    input wire logic homeLvl,
    output var qpc_pkg::qpc_enc_s encOut
);
    import qpc_pkg::*;
    logic [1:0] phaseStep;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            phaseStep <= 2'h0;
        else if (stepGo)
            phaseStep <= stepFwd ? phaseStep + 2'h1 : phaseStep - 2'h1;
    end
    // Only one phase line moves per step; B leads A going forward, which counts up
    always_comb encOut = '{phaseStep[1], phaseStep[0] ^ phaseStep[1], idxLvl, homeLvl};
endmodule
`default_nettype wire

// >>> dv/qpc_position_ctrl_sva.sv
// Port-level assertions for the quadrature position controller
`timescale 1ns/100ps
`default_nettype none
module qpc_position_ctrl_chk (
    input wire logic clk,
    input wire logic rst_b,
    input wire qpc_pkg::qpc_apb_req_s apbReq,
    input wire logic [qpc_pkg::DATA_W-1:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire qpc_pkg::qpc_enc_s encIn,
    input wire logic deviceIdle,
    input wire logic countUp,
    input wire logic counterActive
);
    import qpc_pkg::*;
    logic [CTRL_W-1:0] ctrlShadow;
    logic mapped;
    logic runOn;
    logic haltOn;
    assign mapped = apbReq.paddr <= OFF_STAT && apbReq.paddr[1:0] == 2'h0;
    assign runOn = ctrlShadow[CTRL_RUN_BIT];
    assign haltOn = ctrlShadow[CTRL_HALT_IDLE_BIT];
    // Mirror of what software wrote, so readback is checked against the write
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            ctrlShadow <= CTRL_RESET;
        else if (apbReq.psel && apbReq.penable && pready && apbReq.pwrite
                 && apbReq.paddr == OFF_CTRL)
            ctrlShadow <= apbReq.pwdata[CTRL_W-1:0] & CTRL_WRITE_MASK;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_setup;
        apbReq.psel && !apbReq.penable;
    endsequence
    sequence s_ctrl_read;
        pready && apbReq.psel && apbReq.penable && !apbReq.pwrite && apbReq.paddr == OFF_CTRL;
    endsequence
    property p_ready_after_setup;
        s_setup |=> pready;
    endproperty
    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    property p_err_unmapped;
        s_setup ##0 !mapped |=> pready && pslverr;
    endproperty
    property p_err_mapped;
        s_setup ##0 mapped |=> !pslverr;
    endproperty
    property p_write_zero_data;
        pready && apbReq.pwrite |-> prdata == '0;
    endproperty
    property p_ctrl_readback;
        s_ctrl_read |-> prdata == {16'h0, ctrlShadow};
    endproperty
    property p_stop_disabled;
        (!runOn) [*2] |-> !counterActive;
    endproperty
    property p_run_enabled;
        (runOn && !haltOn) [*2] |-> counterActive;
    endproperty
    property p_idle_halt;
        (runOn && haltOn && deviceIdle) [*2] |-> !counterActive;
    endproperty
    property p_idle_awake;
        (runOn && haltOn && !deviceIdle) [*2] |-> counterActive;
    endproperty
    a_ready_after_setup: assert property (p_ready_after_setup) else $error("no ready after setup");
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
    a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped access not refused");
    a_err_mapped: assert property (p_err_mapped) else $error("mapped access refused");
    a_write_zero_data: assert property (p_write_zero_data) else $error("write returned data");
    a_ctrl_readback: assert property (p_ctrl_readback)
        else $error("control readback wrong");
    a_stop_disabled: assert property (p_stop_disabled)
        else $error("active while disabled");
    a_run_enabled: assert property (p_run_enabled)
        else $error("inactive while enabled");
    a_idle_halt: assert property (p_idle_halt)
        else $error("active in idle with halt set");
    a_idle_awake: assert property (p_idle_awake)
        else $error("inactive out of idle");
endmodule
bind qpc_position_ctrl qpc_position_ctrl_chk qpc_position_ctrl_chk_i (.clk(clk), .rst_b(rst_b),
    .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr), .encIn(encIn),
    .deviceIdle(deviceIdle), .countUp(countUp), .counterActive(counterActive));
`default_nettype wire

// >>> dv/qpc_position_ctrl_tb.sv
// Self-checking bench for the quadrature position controller
`timescale 1ns/100ps
`default_nettype none
module qpc_position_ctrl_tb;
    import qpc_pkg::*;
    typedef struct packed {logic [31:0] d; logic e;} qpc_note_s;
    logic clk, rst_b, deviceIdle, stepGo, stepFwd, idxLvl, homeLvl, pready, pslverr;
    logic countUp, counterActive;
    logic [31:0] prdata, rv;
    logic [15:0] lfsr;
    qpc_apb_req_s apbReq;
    qpc_enc_s encIn;
    qpc_note_s notes[$];
    qpc_note_s nt;
    int n_mismatch, checked;
    qpc_position_ctrl qpc_position_ctrl_i (.clk(clk), .rst_b(rst_b), .apbReq(apbReq),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .encIn(encIn),
        .deviceIdle(deviceIdle), .countUp(countUp), .counterActive(counterActive));
    qpc_enc_model qpc_enc_model_i (.clk(clk), .rst_b(rst_b), .stepGo(stepGo),
        .stepFwd(stepFwd), .idxLvl(idxLvl), .homeLvl(homeLvl), .encOut(encIn));
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    function automatic logic [15:0] lfsr_next(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic tally_and_finish;
        $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // Request held until ready is seen at an edge; the idle cycle first avoids double drives
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [31:0] ed, input logic e);
        notes.push_back('{ed, e});
        @(posedge clk);
        apbReq <= '{1'b1, 1'b0, w, a, d};
        @(posedge clk);
        apbReq.penable <= 1'b1;
        // Only the watchdog ends a wait that never sees ready
        do
            @(posedge clk);
        while (pready !== 1'b1);
        apbReq <= '0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, e, 1'b0);
    endtask
    // Gap of two or more clocks keeps steps under half the sampling rate at divider 0
    task automatic stp(input int n, input logic f, input int gap);
        repeat (n)
        begin
            @(posedge clk);
            stepFwd <= f;
            stepGo <= 1'b1;
            @(posedge clk);
            stepGo <= 1'b0;
            repeat (gap) @(posedge clk);
        end
    endtask
    task automatic pulse(input logic h);
        @(posedge clk);
        if (h)
            homeLvl <= 1'b1;
        else
            idxLvl <= 1'b1;
        repeat (3) @(posedge clk);
        homeLvl <= 1'b0;
        idxLvl <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    always @(posedge clk)
    begin
        if (rst_b && pready === 1'b1)
        begin
            nt = notes.pop_front();
            cmp(prdata, nt.d);
            cmp({31'h0, pslverr}, {31'h0, nt.e});
        end
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        tally_and_finish();
    end
    initial
    begin
        rst_b = 1'b0;
        apbReq = '0;
        {deviceIdle, stepGo, idxLvl, homeLvl} = 4'h0;
        stepFwd = 1'b1;
        lfsr = 16'h7781;
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        rd(OFF_CTRL, 32'h0);
        rd(OFF_POS, 32'h0);
        xfer(1'b1, 8'h18, 32'hffff, 32'h0, 1'b1);
        xfer(1'b0, 8'h1c, 32'h0, 32'h0, 1'b1);
        wr(OFF_CTRL, 32'hffff_6fff);
        rd(OFF_CTRL, 32'h0000_2f7f);
        wr(OFF_CTRL, 32'h0);
        stp(8, 1'b1, 3);
        rd(OFF_POS, 32'h0);
        lfsr = lfsr_next(lfsr);
        rv = {16'h0, lfsr};
        wr(OFF_POS, rv);
        rd(OFF_POS, rv);
        wr(OFF_CTRL, 32'h8000);
        wr(OFF_POS, 32'h0);
        stp(6, 1'b1, 2);
        rd(OFF_POS, 32'h6);
        cmp({31'h0, countUp}, 32'h1);
        wr(OFF_CTRL, 32'ha000);
        deviceIdle <= 1'b1;
        stp(4, 1'b1, 5);
        rd(OFF_POS, 32'h6);
        deviceIdle <= 1'b0;
        stp(2, 1'b1, 2);
        rd(OFF_POS, 32'h8);
        deviceIdle <= 1'b1;
        wr(OFF_CTRL, 32'h8300);
        wr(OFF_POS, 32'h9);
        stp(1, 1'b1, 2);
        pulse(1'b0);
        rd(OFF_POS, 32'ha);
        stp(1, 1'b1, 2);
        pulse(1'b0);
        rd(OFF_POS, 32'h0);
        stp(2, 1'b1, 2);
        deviceIdle <= 1'b0;
        wr(OFF_INCFG, 32'h1);
        // Match value chosen so only the swapped phases meet it
        wr(OFF_CTRL, 32'h8100);
        wr(OFF_POS, 32'h9);
        // Extra gap lets the registered direction settle before it is read
        stp(1, 1'b1, 3);
        cmp({31'h0, countUp}, 32'h0);
        pulse(1'b0);
        rd(OFF_POS, 32'h0);
        stp(1, 1'b0, 2);
        wr(OFF_INCFG, 32'h0);
        wr(OFF_GEC, 32'h3);
        wr(OFF_CTRL, 32'h9400);
        wr(OFF_POS, 32'h0);
        stp(4, 1'b1, 2);
        rd(OFF_POS, 32'h1);
        wr(OFF_INIT, 32'h0);
        wr(OFF_CTRL, 32'h9800);
        wr(OFF_POS, 32'h0);
        stp(4, 1'b1, 2);
        rd(OFF_POS, 32'h0);
        stp(1, 1'b0, 2);
        rd(OFF_POS, 32'h3);
        stp(1, 1'b1, 2);
        lfsr = lfsr_next(lfsr);
        rv = {16'h0, lfsr};
        wr(OFF_INIT, rv);
        wr(OFF_POS, 32'h7);
        wr(OFF_CTRL, 32'h8001);
        pulse(1'b0);
        rd(OFF_POS, 32'h7);
        wr(OFF_CTRL, 32'h8401);
        pulse(1'b0);
        rd(OFF_POS, 32'h0);
        wr(OFF_CTRL, 32'h8801);
        pulse(1'b0);
        rd(OFF_POS, rv);
        wr(OFF_POS, 32'h7);
        pulse(1'b0);
        rd(OFF_POS, 32'h7);
        wr(OFF_CTRL, 32'h8c01);
        pulse(1'b0);
        rd(OFF_POS, 32'h7);
        pulse(1'b1);
        pulse(1'b0);
        rd(OFF_POS, rv);
        wr(OFF_POS, 32'h7);
        wr(OFF_CTRL, 32'h9001);
        pulse(1'b1);
        pulse(1'b0);
        rd(OFF_POS, 32'h7);
        pulse(1'b0);
        rd(OFF_POS, rv);
        // Gated timer counts while index is high; the index reset mode must be ignored
        wr(OFF_CTRL, 32'h8406);
        wr(OFF_POS, 32'h5);
        pulse(1'b0);
        rd(OFF_POS, 32'h8);
        @(posedge clk);
        rst_b <= 1'b0;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        rd(OFF_CTRL, 32'h0);
        rd(OFF_POS, 32'h0);
        repeat (4) @(posedge clk);
        tally_and_finish();
    end
endmodule
`default_nettype wire
